/* File: shared/acg_cfg.svh */
// Constants of the audio codec clock generation block: offsets, counts, positions.
// Assumes inclusion by bare name from the package and both design ends.
`ifndef ACG_CFG_SVH
`define ACG_CFG_SVH
// Clock rate and loss-of-frame time
`define ACG_MCLK_MHZ     100
`define ACG_LOSS_US      300
// Lock detector
`define ACG_LOCK_FRAMES  4'h4
`define ACG_LOCK_TOL     16'h0010
// Recovered clock: 512 half periods per frame give 256 periods per frame
`define ACG_NCO_STEP     17'h00200
// Counter ceilings
`define ACG_GAP_MAX      16'hFFFF
`define ACG_BITS_MAX     8'hFF
`define ACG_OSCS_MAX     10'h3FF
// Link pin positions and synchroniser positions
`define ACG_PIN_CAPF     0
`define ACG_PIN_CAPB     1
`define ACG_PIN_PLAYF    2
`define ACG_PIN_PLAYB    3
`define ACG_SY_OSC       4
// Device master divider phase bits
`define ACG_FRAME_BIT    7
`define ACG_BIT_BIT      2
// Quiet cycles after a master tick before the source may change
`define ACG_SWITCH_GAP   2'h3
// Legal bit clocks and oscillator ticks per frame
`define ACG_BR_32        8'h20
`define ACG_BR_48        8'h30
`define ACG_BR_64        8'h40
`define ACG_BR_128       8'h80
`define ACG_OR_256       10'h100
`define ACG_OR_384       10'h180
`define ACG_OR_512       10'h200
// Host register map and fields
`define ACG_ADR_W        4
`define ACG_REG_CTRL     4'h0
`define ACG_REG_STATUS   4'h4
`define ACG_CTRL_W       10
`define ACG_OSC_STOP_BIT 10
// Host oscillator and slave clock generator
`define ACG_OSC_HALF     8'h04
`define ACG_H_FRAME      8
`define ACG_H_BIT        2
`define ACG_H_BIT_OLM    1
`endif

/* File: shared/acg_pkg.sv */
// Types shared by both ends of the clock generation link.
// Assumes acg_cfg.svh is on the include path.
`include "acg_cfg.svh"
package acg_pkg;
	// Master clock source switch modes
	typedef enum logic [1:0] {
		manual_oscillator,
		manual_pll,
		auto_changeover,
		auto_changeover_spare
	} acg_switch_t;
	// Speed modes
	typedef enum logic [1:0] {
		single_rate_setting,
		double_rate_setting,
		quad_rate_setting,
		reserved_rate
	} acg_speed_t;
	// Single-data-line multichannel modes
	typedef enum logic [1:0] {
		olm_off,
		olm_one,
		olm_two,
		olm_spare
	} acg_olm_t;
	// Control word, host to device
	typedef struct packed {
		acg_olm_t    one_line_mode;
		acg_speed_t  speed_select_field;
		logic        capture_port_master_select;
		logic        playback_port_master_select;
		logic        force_pll_locked;
		logic        pll_reference_select;
		acg_switch_t clock_source_switch_field;
	} acg_ctrl_t;
	// Status word, device to host; index 0 capture, 1 playback
	typedef struct packed {
		logic [1:0] frame_lost;
		logic [1:0] ratio_err;
		logic [1:0] eff_master;
		logic       cfg_err;
		logic       pll_locked;
		logic       pll_active;
	} acg_status_t;
	// Legal bit clocks per frame for a slave port
	function automatic logic acg_bits_ok(acg_olm_t olm, acg_speed_t sp, logic [7:0] n);
		if (olm == olm_one) begin
			return n == `ACG_BR_128;
		end
		return n == `ACG_BR_32 || n == `ACG_BR_48 || n == `ACG_BR_64
			|| (sp == single_rate_setting && n == `ACG_BR_128);
	endfunction
	// Legal oscillator ticks per frame; speed must be clamped already
	function automatic logic acg_osc_ok(acg_olm_t olm, acg_speed_t sp, logic [9:0] n);
		if (olm == olm_one) begin
			return n == `ACG_OR_256;
		end
		return n == (`ACG_OR_256 >> sp) || n == (`ACG_OR_384 >> sp) || n == (`ACG_OR_512 >> sp);
	endfunction
endpackage

/* File: shared/acg_if.sv */
// Link between the codec clock generator and its controller.
// Pins are resolved here from the two enables; an undriven pin reads low.
`timescale 1ns/1ns
interface acg_link_if;
	logic                osc_clk;      // Oscillator clock, host drives
	logic                recovered_master_clock_out;         // Recovered master clock, device drives
	logic [3:0]          dev_pin;      // Frame and bit clocks, device side
	logic [3:0]          dev_pin_oe_b; // Low while the device drives
	logic [3:0]          host_pin;     // Frame and bit clocks, host side
	logic [3:0]          host_pin_oe_b;// Low while the host drives
	logic [3:0]          pin;          // Resolved wire level
	acg_pkg::acg_ctrl_t   ctrl;         // Control word
	acg_pkg::acg_status_t status;       // Status word
	// Device wins a clash so the wire never goes unknown
	assign pin = (~dev_pin_oe_b & dev_pin) | (dev_pin_oe_b & ~host_pin_oe_b & host_pin);
	modport dev (
		input  osc_clk, pin, ctrl,
		output recovered_master_clock_out, dev_pin, dev_pin_oe_b, status
	);
	modport host (
		input  recovered_master_clock_out, pin, status,
		output osc_clk, host_pin, host_pin_oe_b, ctrl
	);
endinterface

/* File: rtl/acg_device.sv */
// Codec clock generation: source switch, recovered clock, port dividers, slave checks.
// Assumes the controller holds ctrl on the same mclk_in; link pins are asynchronous.
//
// Contract
// - Master clock from PLL or oscillator, switchable
// - Reference bit locks PLL, 256Fs recovered clock
// - Auto mode falls to oscillator glitch-free
// - Far end keeps oscillator running unless forced
// - Master timing from oscillator or PLL
// - Both ports master only on oscillator
// - On PLL, capture port slave, playback free
// - Far end slave frames synchronous, at Fs
// - Recovered clock 256Fs in every speed
// - Slave bit clock 128/64/48/32 Fs, synchronous
// - Oscillator at least twice fastest bit clock; at quad speed the far end gives a bit clock at the oscillator rate
// - Slave port frame clock always present
// - Slave supports one-line mode one only
// - Slave oscillator-to-frame ratios per speed
// - Slave bit-to-frame ratios per speed
// - Speed field picks single, double, quad
// - Per-port master select drives or accepts clocks
`timescale 1ns/1ns
`include "acg_cfg.svh"
module acg_device #(
	parameter logic [15:0] LOSS_CYC = 16'(`ACG_LOSS_US * `ACG_MCLK_MHZ)
) (
	// Clock and reset
	input  wire logic mclk_in,
	input  wire logic rst_b_in,
	// Link to the controller
	acg_link_if.dev   link,
	// User side
	output logic      master_tick_out,
	output logic      pll_locked_out
);
	// Whole state of the device end
	typedef struct packed {
		logic [4:0]       sy1;       // First synchroniser stage
		logic [4:0]       sy2;       // Second synchroniser stage
		logic [4:0]       prev;      // Edge detector history
		logic [1:0][15:0] gap;       // Cycles since last frame edge
		logic [1:0][7:0]  bits;      // Bit clocks counted in a frame
		logic [1:0][9:0]  oscs;      // Oscillator ticks counted in a frame
		logic [15:0]      period;    // Last capture frame period
		logic [3:0]       lock_cnt;  // Stable frames seen
		logic [15:0]      acc;       // Recovered clock accumulator
		logic             recovered_master_clock_out;      // Recovered clock level
		logic             use_pll;   // Active master clock source
		logic             tick;      // Master clock tick, registered
		logic [1:0]       quiet;     // Cycles since the last master tick
		logic [7:0]       phase;     // Master divider phase
		logic [3:0]       pin;       // Driven frame and bit levels
		logic [3:0]       pin_oe_b;  // Pin enables, low drives
		acg_pkg::acg_status_t status; // Reported status
	} acg_dev_state_t;

	acg_dev_state_t     s;          // Registered state
	acg_dev_state_t     next_s;     // Next state
	acg_pkg::acg_ctrl_t ctrl;       // Control word, same clock domain
	acg_pkg::acg_speed_t sp;        // Speed with reserved clamped to quad
	logic [4:0]         rise;       // Rising edges on synchronised inputs
	logic               osc_tick;   // Oscillator rising edge
	logic               pll_tick;   // Recovered clock rising edge
	logic               mtick;      // Selected master clock tick
	logic               want_pll;   // Source asked for by the switch
	logic               locked;     // Lock indicator
	logic [16:0]        acc2;       // Accumulator sum
	logic [15:0]        diff;       // Period drift
	logic [7:0]         step;       // Phase step per master tick
	logic [1:0]         slave;      // Ports running as slave

	assign ctrl = link.ctrl;

	// Next-state logic for the whole device end
	always_comb begin
		next_s = s;
		rise = s.sy2 & ~s.prev;
		osc_tick = rise[`ACG_SY_OSC];
		pll_tick = 1'b0;
		acc2 = '0;
		diff = '0;
		want_pll = 1'b0;
		// Reserved speed code behaves as quad and is flagged below
		if (ctrl.speed_select_field == acg_pkg::reserved_rate) begin
			sp = acg_pkg::quad_rate_setting;
		end else begin
			sp = ctrl.speed_select_field;
		end

		// Two flops ahead of the oscillator and every link pin, not ctrl; only sy2 is looked at
		next_s.sy1 = {link.osc_clk, link.pin};
		next_s.sy2 = s.sy1;
		next_s.prev = s.sy2;

		// Lock detector on the capture frame clock
		if (rise[`ACG_PIN_CAPF]) begin
			if (s.gap[0] > s.period) begin
				diff = s.gap[0] - s.period;
			end else begin
				diff = s.period - s.gap[0];
			end
			next_s.period = s.gap[0];
			if (!ctrl.pll_reference_select || diff > `ACG_LOCK_TOL) begin
				next_s.lock_cnt = '0;
			end else if (s.lock_cnt != `ACG_LOCK_FRAMES) begin
				next_s.lock_cnt = s.lock_cnt + 4'h1;
			end
		end else if (s.gap[0] >= LOSS_CYC || !ctrl.pll_reference_select) begin
			// Frame clock gone: lock drops without waiting for an edge
			next_s.lock_cnt = '0;
		end
		locked = ctrl.force_pll_locked || s.lock_cnt == `ACG_LOCK_FRAMES;

		// Recovered clock: 256 periods per measured frame, whatever the speed
		// Limitation: at most one edge per mclk cycle, so fast rates jitter by a cycle
		if (locked) begin
			acc2 = {1'b0, s.acc} + `ACG_NCO_STEP;
			if (acc2 >= {1'b0, s.period}) begin
				next_s.acc = 16'(acc2 - {1'b0, s.period});
				next_s.recovered_master_clock_out = ~s.recovered_master_clock_out;
				pll_tick = ~s.recovered_master_clock_out;
			end else begin
				next_s.acc = acc2[15:0];
			end
		end else begin
			next_s.acc = '0;
			next_s.recovered_master_clock_out = 1'b0;
		end

		// Source switch
		case (ctrl.clock_source_switch_field)
			acg_pkg::manual_oscillator: begin
				want_pll = 1'b0;
			end
			acg_pkg::manual_pll: begin
				want_pll = 1'b1;
			end
			default: begin
				// Spare code acts as the auto mode
				want_pll = locked;
			end
		endcase
		// Changing only after a quiet stretch keeps the master tick free of runts:
		// the first tick of the new source lands at least five cycles after the last old one
		if (!osc_tick && !pll_tick && s.quiet == `ACG_SWITCH_GAP) begin
			next_s.use_pll = want_pll;
		end
		mtick = s.use_pll ? pll_tick : osc_tick;
		next_s.tick = mtick;
		// Quiet counter saturates, so a source that stopped never blocks the switch
		if (mtick) begin
			next_s.quiet = '0;
		end else if (s.quiet != `ACG_SWITCH_GAP) begin
			next_s.quiet = s.quiet + 2'h1;
		end

		// Master divider: PLL is always 256Fs, oscillator steps by speed
		if (s.use_pll) begin
			step = 8'h01;
		end else begin
			step = 8'h01 << sp;
		end
		if (mtick) begin
			next_s.phase = s.phase + step;
		end

		// Effective master per port; capture yields on PLL
		next_s.status.eff_master[0] = ctrl.capture_port_master_select & ~s.use_pll;
		next_s.status.eff_master[1] = ctrl.playback_port_master_select;
		slave = ~next_s.status.eff_master;
		next_s.status.cfg_err = (ctrl.capture_port_master_select & s.use_pll)
			| ((|slave) & (ctrl.one_line_mode == acg_pkg::olm_two))
			| (ctrl.speed_select_field == acg_pkg::reserved_rate);
		next_s.status.pll_locked = locked;
		next_s.status.pll_active = s.use_pll;

		// Per-port drive and slave checks
		for (int p = 0; p < 2; p++) begin
			// Master ports drive divided clocks, slaves release the pins
			next_s.pin[2 * p] = ~next_s.phase[`ACG_FRAME_BIT];
			next_s.pin[2 * p + 1] = next_s.phase[`ACG_BIT_BIT];
			next_s.pin_oe_b[2 * p] = slave[p];
			next_s.pin_oe_b[2 * p + 1] = slave[p];
			// Frame gap counter saturates
			if (rise[2 * p]) begin
				next_s.gap[p] = '0;
			end else if (s.gap[p] != `ACG_GAP_MAX) begin
				next_s.gap[p] = s.gap[p] + 16'h0001;
			end
			next_s.status.frame_lost[p] = slave[p] & (s.gap[p] >= LOSS_CYC);
			// Ratio check at each frame edge
			if (rise[2 * p]) begin
				next_s.status.ratio_err[p] = slave[p]
					& (!acg_pkg::acg_bits_ok(ctrl.one_line_mode, sp, s.bits[p])
					| (!s.use_pll & !acg_pkg::acg_osc_ok(ctrl.one_line_mode, sp, s.oscs[p])));
				next_s.bits[p] = '0;
				next_s.oscs[p] = '0;
			end else begin
				if (rise[2 * p + 1] && s.bits[p] != `ACG_BITS_MAX) begin
					next_s.bits[p] = s.bits[p] + 8'h01;
				end
				if (osc_tick && s.oscs[p] != `ACG_OSCS_MAX) begin
					next_s.oscs[p] = s.oscs[p] + 10'h001;
				end
			end
		end
	end

	// State register; pins released during reset
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			s <= '0;
			s.pin_oe_b <= '1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from state
	assign link.recovered_master_clock_out = s.recovered_master_clock_out;
	assign link.dev_pin = s.pin;
	assign link.dev_pin_oe_b = s.pin_oe_b;
	assign link.status = s.status;
	assign master_tick_out = s.tick;
	assign pll_locked_out = s.status.pll_locked;
endmodule

/* File: rtl/acg_host.sv */
// Controller end: Wishbone registers, oscillator divider, slave clock generator.
// Assumes a classic Wishbone master on mclk_in and the device on the same clock.
`timescale 1ns/1ns
`include "acg_cfg.svh"
module acg_host (
	// Clock and reset
	input  wire logic                  mclk_in,
	input  wire logic                  rst_b_in,
	// Wishbone slave
	input  wire logic                  wb_cyc_in,
	input  wire logic                  wb_stb_in,
	input  wire logic                  wb_we_in,
	input  wire logic [`ACG_ADR_W-1:0] wb_adr_in,
	input  wire logic [3:0]            wb_sel_in,
	input  wire logic [31:0]           wb_dat_in,
	output logic      [31:0]           wb_dat_out,
	output logic                       wb_ack_out,
	// Link to the device
	acg_link_if.host                   link
);
	// Whole state of the host end
	typedef struct packed {
		acg_pkg::acg_ctrl_t ctrl;     // Control register
		logic               osc_stop; // Stop request for the oscillator
		logic               ack;      // Bus acknowledge
		logic [31:0]        dat;      // Bus read data
		logic [7:0]         div;      // Oscillator divider
		logic               osc;      // Oscillator level
		logic [8:0]         h;        // Oscillator half periods
		logic [3:0]         pin;      // Slave clock levels
		logic [3:0]         pin_oe_b; // Pin enables, low drives
	} acg_host_state_t;

	acg_host_state_t     s;      // Registered state
	acg_host_state_t     next_s; // Next state
	logic [31:0]         w;      // Control register image
	logic                half;   // Oscillator half-period pulse
	acg_pkg::acg_speed_t sp;     // Clamped speed
	int unsigned         fidx;   // Frame bit of the half counter
	int unsigned         bidx;   // Bit clock bit of the half counter

	// Next-state logic
	always_comb begin
		next_s = s;
		w = '0;
		w[`ACG_CTRL_W-1:0] = s.ctrl;
		w[`ACG_OSC_STOP_BIT] = s.osc_stop;
		half = 1'b0;
		// Bus: ack one cycle after the request, gone the cycle after
		next_s.ack = wb_cyc_in & wb_stb_in & ~s.ack;
		if (next_s.ack) begin
			if (wb_adr_in == `ACG_REG_CTRL) begin
				next_s.dat = w;
			end else if (wb_adr_in == `ACG_REG_STATUS) begin
				next_s.dat = 32'(link.status);
			end else begin
				// Unmapped: reads zero, writes dropped
				next_s.dat = '0;
			end
			if (wb_we_in && wb_adr_in == `ACG_REG_CTRL) begin
				for (int b = 0; b < 4; b++) begin
					if (wb_sel_in[b]) begin
						w[8 * b +: 8] = wb_dat_in[8 * b +: 8];
					end
				end
				next_s.ctrl = acg_pkg::acg_ctrl_t'(w[`ACG_CTRL_W-1:0]);
				next_s.osc_stop = w[`ACG_OSC_STOP_BIT];
			end
		end
		// Oscillator divider
		if (s.div == `ACG_OSC_HALF - 8'h01) begin
			next_s.div = '0;
			half = 1'b1;
		end else begin
			next_s.div = s.div + 8'h01;
		end
		// Oscillator may only stop while lock is forced
		if (half && !(s.osc_stop && s.ctrl.force_pll_locked)) begin
			next_s.osc = ~s.osc;
			next_s.h = s.h + 9'h001;
		end
		// Slave clocks: frame 256>>speed oscillator periods, bit 64 per frame, 128>>speed per frame in one-line mode one
		if (s.ctrl.speed_select_field == acg_pkg::reserved_rate) begin
			sp = acg_pkg::quad_rate_setting;
		end else begin
			sp = s.ctrl.speed_select_field;
		end
		fidx = `ACG_H_FRAME - 32'(sp);
		if (s.ctrl.one_line_mode == acg_pkg::olm_one) begin
			bidx = `ACG_H_BIT_OLM;
		end else begin
			bidx = `ACG_H_BIT - 32'(sp);
		end
		next_s.pin[`ACG_PIN_CAPF] = ~next_s.h[fidx];
		next_s.pin[`ACG_PIN_CAPB] = next_s.h[bidx];
		next_s.pin[`ACG_PIN_PLAYF] = ~next_s.h[fidx];
		next_s.pin[`ACG_PIN_PLAYB] = next_s.h[bidx];
		// Drive a port only while the device runs it as slave
		next_s.pin_oe_b[`ACG_PIN_CAPF] = link.status.eff_master[0];
		next_s.pin_oe_b[`ACG_PIN_CAPB] = link.status.eff_master[0];
		next_s.pin_oe_b[`ACG_PIN_PLAYF] = link.status.eff_master[1];
		next_s.pin_oe_b[`ACG_PIN_PLAYB] = link.status.eff_master[1];
	end

	// State register; pins released during reset
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			s <= '0;
			s.pin_oe_b <= '1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from state
	assign wb_dat_out = s.dat;
	assign wb_ack_out = s.ack;
	assign link.osc_clk = s.osc;
	assign link.host_pin = s.pin;
	assign link.host_pin_oe_b = s.pin_oe_b;
	assign link.ctrl = s.ctrl;
endmodule

/* File: testbench/acg_chk.sv */
// Checker for the clock generation link: watches the interface beside the two ends.
// Assumes acg_pkg is compiled first; one clock domain, reset synchronous active low.
`timescale 1ns/1ns
module acg_chk (
	// Clock and reset
	input  wire logic                 mclk_in,
	input  wire logic                 rst_b_in,
	// Link signals
	input  wire logic                 osc_clk,
	input  wire logic                 recovered_master_clock_out,
	input  wire logic [3:0]           dev_pin_oe_b,
	input  wire acg_pkg::acg_ctrl_t   ctrl,
	input  wire acg_pkg::acg_status_t status,
	// Device user side
	input  wire logic                 master_tick_out,
	input  wire logic                 pll_locked_out
);
	logic [4:0] osc_idle; // Cycles since the oscillator last moved
	logic [7:0] unl_cnt;  // Cycles spent without lock

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_b_in);

	// Saturating counters keep long waits out of repetition operators
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			osc_idle <= 5'h00;
			unl_cnt  <= 8'h00;
		end else begin
			if ($changed(osc_clk))
				osc_idle <= 5'h00;
			else if (osc_idle != 5'h1F)
				osc_idle <= osc_idle + 5'h01;
			if (pll_locked_out)
				unl_cnt <= 8'h00;
			else if (unl_cnt != 8'hFF)
				unl_cnt <= unl_cnt + 8'h01;
		end
	end

	a_cap_slave_pll: assert property (status.pll_active |-> !status.eff_master[0])
		else $error("capture port master while on the recovered clock");
	a_dual_on_osc: assert property (&status.eff_master |-> !status.pll_active)
		else $error("both ports master while not on the oscillator");
	a_tick_spacing: assert property (master_tick_out |=> !master_tick_out [*3])
		else $error("master clock tick closer than four cycles");
	a_no_cap_drive: assert property (
		status.pll_active && $past(status.pll_active, 2) |-> &dev_pin_oe_b[1:0])
		else $error("device drives capture clocks while on the recovered clock");
	a_reserved_speed: assert property (
		$rose(ctrl.speed_select_field == acg_pkg::reserved_rate) |-> ##[1:3] status.cfg_err)
		else $error("reserved speed not flagged");
	a_forced_lock: assert property (ctrl.force_pll_locked [*3] |-> pll_locked_out)
		else $error("forced lock not shown");
	a_osc_half: assert property ($changed(osc_clk) |=> $stable(osc_clk) [*3])
		else $error("oscillator half period shorter than four cycles");
	a_osc_runs: assert property (osc_idle < 5'h08 || ctrl.force_pll_locked)
		else $error("oscillator stopped without forced lock");
	a_unlock_recovered_master_clock_out: assert property (unl_cnt >= 8'd20 |-> !recovered_master_clock_out)
		else $error("recovered clock runs without lock");

	// Main scenarios
	c_pll: cover property (status.pll_active && status.pll_locked);
	c_dual: cover property (&status.eff_master);
	c_cfg: cover property (status.cfg_err);
	c_force: cover property (ctrl.force_pll_locked && pll_locked_out);
endmodule

/* File: testbench/tb_top.sv */
// Bench joining device and controller over the link; drives the controller by Wishbone.
// Assumes the package, interface and both design ends are compiled before it.
`timescale 1ns/1ns
module tb_top;
	logic                 mclk_in = 1'b0;  // System clock
	logic                 rst_b_in = 1'b0; // Reset, active low
	logic                 wb_cyc = 1'b0;   // Bus request
	logic                 wb_stb = 1'b0;
	logic                 wb_we = 1'b0;
	logic [3:0]           wb_adr = 4'h0;
	logic [31:0]          wb_dat = 32'h0;
	logic [31:0]          wb_rd;           // Read data
	logic                 wb_ack;
	logic                 tick;            // Device master tick
	logic                 locked;          // Device lock indicator
	logic [31:0]          q;               // Last read word
	logic [31:0]          d;               // Random control word
	acg_pkg::acg_status_t st;              // Last status word
	int                   fail_count = 0;
	int                   samples_checked = 0;
	int                   seed = 51;
	int                   per, nb, nr, i;
	int unsigned          exp_q[$];        // Model of control readback

	acg_link_if link();
	acg_device #(.LOSS_CYC(16'd3000)) acg_device_i (
		.mclk_in(mclk_in), .rst_b_in(rst_b_in), .link(link),
		.master_tick_out(tick), .pll_locked_out(locked));
	// Byte lanes tied: every access is a full word
	acg_host acg_host_i (
		.mclk_in(mclk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
		.wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(4'hF), .wb_dat_in(wb_dat),
		.wb_dat_out(wb_rd), .wb_ack_out(wb_ack), .link(link));
	acg_chk acg_chk_i (
		.mclk_in(mclk_in), .rst_b_in(rst_b_in), .osc_clk(link.osc_clk), .recovered_master_clock_out(link.recovered_master_clock_out),
		.dev_pin_oe_b(link.dev_pin_oe_b), .ctrl(link.ctrl), .status(link.status),
		.master_tick_out(tick), .pll_locked_out(locked));

	// 100 MHz clock
	always #5 mclk_in = ~mclk_in;

	// Verdict and end of run, shared by the main sequence and every timeout
	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// A wait that runs out counts as a mismatch
	task automatic tmo(input string nm);
		fail_count++;
		$display("MISMATCH %s expected 1 seen 0", nm);
		report_and_stop();
	endtask

	// Compare one result against the model
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	// Classic single cycle; holds everything until ack is sampled high
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] dw);
		int n;
		@(posedge mclk_in);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= dw;
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50) tmo("wb_ack");
		q = wb_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask

	// One frame of port i: length, bit clocks and recovered clocks inside it
	task automatic meas(input int ix);
		int n, s;
		logic pf, pb, pr;
		s = 0;
		per = 0;
		nb = 0;
		nr = 0;
		pf = link.pin[ix];
		pb = link.pin[ix+1];
		pr = link.recovered_master_clock_out;
		for (n = 0; n < 20000 && s < 2; n++) begin
			@(negedge mclk_in);
			if (s == 1) begin
				per++;
				nb += (!pb && link.pin[ix+1]);
				nr += (!pr && link.recovered_master_clock_out);
			end
			s += (!pf && link.pin[ix]);
			pf = link.pin[ix];
			pb = link.pin[ix+1];
			pr = link.recovered_master_clock_out;
		end
		if (s < 2) tmo("frame_edge");
	endtask

	// Write control, let one frame settle, measure one, read status
	task automatic run(input logic [31:0] c, input int ix);
		wb(1'b1, `ACG_REG_CTRL, c);
		meas(ix);
		meas(ix);
		wb(1'b0, `ACG_REG_STATUS, 32'h0);
		st = q[8:0];
	endtask

	initial begin
		repeat (12) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		// Reset values and an unmapped place
		wb(1'b0, `ACG_REG_CTRL, 32'h0);
		chk("ctrl_reset", 32'h0, q);
		wb(1'b0, 4'h8, 32'h0);
		chk("unmapped_read", 32'h0, q);
		$display("test reset done");
		// Random control words read back; reserved speed kept for its own test
		// Forced lock kept out: no frame is measured yet, so the recovered clock would race
		for (i = 0; i < 4; i++) begin
			d = $random(seed);
			d[10] = 1'b0;
			d[3] = 1'b0;
			if (d[7:6] == 2'h3) d[7] = 1'b0;
			exp_q.push_back(d & 32'h3FF);
			wb(1'b1, `ACG_REG_CTRL, d);
			wb(1'b0, `ACG_REG_CTRL, 32'h0);
			chk("ctrl_read", exp_q.pop_front(), q);
		end
		wb(1'b1, 4'h8, 32'hFFFFFFFF);
		wb(1'b0, `ACG_REG_CTRL, 32'h0);
		chk("ctrl_kept", d & 32'h3FF, q);
		$display("test registers done");
		// Both ports slave at each legal speed: host clocks in legal ratios
		for (i = 0; i < 3; i++) begin
			run(i << 6, 0);
			chk("frame_len", (256 >> i) * 8, per);
			chk("bits_frame", 64, nb);
			chk("ratio_err", 2'h0, st.ratio_err);
			chk("cfg_err", 0, st.cfg_err);
			chk("frame_lost", 2'h0, st.frame_lost);
		end
		run(32'h0C0, 0);
		chk("cfg_reserved", 1, st.cfg_err);
		run(32'h100, 0);
		chk("bits_olm1", 128, nb);
		chk("err_olm1", 3'h0, {st.cfg_err, st.ratio_err});
		run(32'h200, 0);
		chk("cfg_olm2", 1, st.cfg_err);
		// One-line mode one at double speed: half the ticks and bits it needs
		run(32'h140, 0);
		chk("ratio_olm_dbl", 2'h3, st.ratio_err);
		$display("test slave ratios done");
		// Both ports master on the oscillator
		run(32'h030, 0);
		chk("eff_master", 2'h3, st.eff_master);
		chk("dev_frame", 2048, per);
		chk("dev_bits", 32, nb);
		chk("src_osc", 0, st.pll_active);
		meas(2);
		chk("play_frame", 2048, per);
		$display("test master done");
		// Lock to the capture frame in automatic mode
		wb(1'b1, `ACG_REG_CTRL, 32'h006);
		st = '0;
		for (i = 0; i < 40 && st.pll_active !== 1'b1; i++) begin
			repeat (500) @(posedge mclk_in);
			wb(1'b0, `ACG_REG_STATUS, 32'h0);
			st = q[8:0];
		end
		chk("pll_locked", 1, st.pll_locked);
		chk("lock_out", 1, locked);
		meas(0);
		chk("recovered_master_clock_out_256", 1, nr >= 255 && nr <= 257);
		run(32'h036, 2);
		chk("cap_refused", 1, st.cfg_err);
		chk("eff_master_pll", 2'h2, st.eff_master);
		chk("still_pll", 1, st.pll_active);
		$display("test pll done");
		// Forced lock
		run(32'h008, 0);
		chk("forced_lock", 1, st.pll_locked);
		$display("test force done");
		report_and_stop();
	end
endmodule
